// ---- rrx_pkg.sv ----
// Package for the return and rotate instruction executor
package rrx_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 16;
   localparam logic [15:0] OP_NOP = 16'h0000;
   localparam logic [15:0] OP_RET_INT = 16'h0005;
   localparam logic [15:0] OP_RET_SUB = 16'h0002;
   localparam logic [7:0] OP_RET_LIT_HI = 8'hb6;
   localparam logic [6:0] OP_ROT_LC_HI = 7'h0d;
   localparam int GIE_DIS_BIT = 4;
   localparam int CARRY_BIT = 0;
   localparam int PC_HI_LSB = 8;
   localparam int Q_PHASES = 4;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_EXEC = 2'h2;
   typedef enum logic [2:0] {RRX_OP_NOP, RRX_OP_RETI, RRX_OP_RETL, RRX_OP_RET, RRX_OP_RLC, RRX_OP_OTHER} rrx_op_t;
   typedef enum {RRX_ST_FIRST, RRX_ST_FORCED} rrx_state_t;
endpackage

// ---- rrx_dec_if.sv ----
// Interface carrying decoded instruction fields to the executor
`timescale 1ns/10ps
interface rrx_dec_if;
   import rrx_pkg::*;
   rrx_op_t op;
   logic dest_file;
   logic [7:0] field;
   modport dec (output op, output dest_file, output field);
   modport exe (input op, input dest_file, input field);
endinterface

// ---- rrx_decoder.sv ----
// Combinational instruction word decoder
`timescale 1ns/10ps
module rrx_decoder (
   input wire logic [15:0] i_instr,
   rrx_dec_if.dec o_dec
);
   import rrx_pkg::*;
   always_comb begin
      o_dec.field = i_instr[7:0];
      o_dec.dest_file = i_instr[8];
      if (i_instr == OP_RET_INT) begin
         o_dec.op = RRX_OP_RETI; // (RQ2)
      end else if (i_instr == OP_RET_SUB) begin
         o_dec.op = RRX_OP_RET; // (RQ9)
      end else if (i_instr == OP_NOP) begin
         o_dec.op = RRX_OP_NOP; // (RQ12)
      end else if (i_instr[15:8] == OP_RET_LIT_HI) begin
         o_dec.op = RRX_OP_RETL; // (RQ7)
      end else if (i_instr[15:9] == OP_ROT_LC_HI) begin
         o_dec.op = RRX_OP_RLC; // (RQ13)
      end else begin
         o_dec.op = RRX_OP_OTHER;
      end
   end
endmodule // rrx_decoder

// ---- rrx_core.sv ----
// Return and rotate instruction executor, four-phase instruction cycle
//
// Notes on behaviour
// (RQ1) Return from interrupt pops stack into PC; high latch unchanged.
// (RQ2) Word 0x0005 is return from interrupt: two cycles, second forced no-op.
// (RQ3) Return from interrupt clears global interrupt disable only.
// (RQ4) Global interrupt disable is status register bit 4.
// (RQ5) Return with literal loads literal into working register; flags untouched.
// (RQ6) Return with literal loads PC from stack top and pops.
// (RQ7) Opcode 0xb6 plus literal: one word, two cycles, second forced no-op.
// (RQ8) Return with literal leaves the PC high latch unchanged.
// (RQ9) Word 0x0002 is subroutine return: pops stack into PC, no flags.
// (RQ10) Subroutine return: PC low read first cycle, forced no-op second.
// (RQ11) Reading PC low byte loads high latch with executing instruction's high address.
// (RQ12) All-zero word is a one-cycle no-op changing nothing.
// (RQ13) Rotate left through carry; d=0 to working register, d=1 to file.
`timescale 1ns/10ps
module rrx_core (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [rrx_pkg::PC_W-1:0] i_instr_addr,
   input wire logic [rrx_pkg::PC_W-1:0] i_stack_top,
   input wire logic [rrx_pkg::DATA_W-1:0] i_file_rdata,
   input wire logic [rrx_pkg::DATA_W-1:0] i_status_in,
   output logic o_instr_ready,
   output logic o_busy,
   output logic [1:0] o_q_phase,
   output logic [rrx_pkg::PC_W-1:0] o_pc,
   output logic o_pc_load,
   output logic o_stack_pop,
   output logic [rrx_pkg::DATA_W-1:0] o_pc_high_latch,
   output logic [rrx_pkg::DATA_W-1:0] o_working_register,
   output logic [rrx_pkg::DATA_W-1:0] o_cpu_status_register,
   output logic [7:0] o_file_addr,
   output logic o_file_we,
   output logic [rrx_pkg::DATA_W-1:0] o_file_wdata,
   output logic o_unknown
);
   import rrx_pkg::*;

   rrx_dec_if dec_if ();

   rrx_decoder u_dec (
      .i_instr(i_instr),
      .o_dec(dec_if.dec)
   );

   rrx_state_t state_r, state_nxt;
   logic [1:0] q_r, q_nxt;
   rrx_op_t op_r, op_nxt;
   logic dest_r, dest_nxt;
   logic [7:0] field_r, field_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt, iaddr_r, iaddr_nxt;
   logic pc_load_r, pc_load_nxt, pop_r, pop_nxt;
   logic [DATA_W-1:0] pc_high_latch_r, pc_high_latch_nxt, working_register_r, working_register_nxt, sta_r, sta_nxt;
   logic [DATA_W-1:0] fwd_r, fwd_nxt;
   logic fwe_r, fwe_nxt, unk_r, unk_nxt, rdy_r, rdy_nxt;
   logic [DATA_W-1:0] rot;
   logic take;
   logic busy_r, busy_nxt;

   // Returns own two instruction cycles, the second a forced no-op
   function automatic logic is_return(input rrx_op_t op);
      return (op == RRX_OP_RETI) || (op == RRX_OP_RETL) || (op == RRX_OP_RET);
   endfunction

   // Status register mirrors the core's copy except when we own it
   always_comb begin
      rot = {i_file_rdata[DATA_W-2:0], i_status_in[CARRY_BIT]};
      state_nxt = state_r;
      q_nxt = q_r + 2'h1;
      op_nxt = op_r;
      dest_nxt = dest_r;
      field_nxt = field_r;
      iaddr_nxt = iaddr_r;
      pc_nxt = pc_r;
      pc_load_nxt = 1'b0;
      pop_nxt = 1'b0;
      pc_high_latch_nxt = pc_high_latch_r;
      working_register_nxt = working_register_r;
      sta_nxt = sta_r;
      fwd_nxt = fwd_r;
      fwe_nxt = 1'b0;
      unk_nxt = 1'b0;
      rdy_nxt = 1'b0;
      take = 1'b0;
      case (state_r)
         RRX_ST_FIRST: begin
            if (q_r == Q_EXEC) begin
               // Ready stands in the phase whose closing edge takes the next word
               rdy_nxt = !is_return(op_r);
               case (op_r)
                  RRX_OP_RETI: begin
                     pc_nxt = i_stack_top; // (RQ1)
                     pc_load_nxt = 1'b1;
                     pop_nxt = 1'b1; // (RQ1)
                     // Only the disable bit moves
                     sta_nxt[GIE_DIS_BIT] = 1'b0; // (RQ3) (RQ4)
                  end
                  RRX_OP_RETL: begin
                     working_register_nxt = field_r; // (RQ5)
                     pc_nxt = i_stack_top; // (RQ6)
                     pc_load_nxt = 1'b1;
                     // Latch untouched: no PC low read here
                     pop_nxt = 1'b1; // (RQ6) (RQ8)
                  end
                  RRX_OP_RET: begin
                     // PC low read refreshes the high latch
                     pc_high_latch_nxt = iaddr_r[PC_W-1:PC_HI_LSB]; // (RQ10) (RQ11)
                     pc_nxt = i_stack_top; // (RQ9)
                     pc_load_nxt = 1'b1;
                     pop_nxt = 1'b1;
                  end
                  RRX_OP_RLC: begin
                     // Carry in is the live status input
                     sta_nxt[CARRY_BIT] = i_file_rdata[DATA_W-1]; // (RQ13)
                     if (dest_r) begin
                        fwd_nxt = rot;
                        fwe_nxt = 1'b1;
                     end else begin
                        working_register_nxt = rot; // (RQ13)
                     end
                  end
                  RRX_OP_OTHER: begin
                     // Unknown words only raise a flag; no state moves
                     unk_nxt = 1'b1;
                  end
                  default: ; // (RQ12)
               endcase
            end
            if (q_r == Q_LAST) begin
               if (is_return(op_r)) begin
                  // Return op is held, but the forced cycle never executes it
                  state_nxt = RRX_ST_FORCED; // (RQ2) (RQ7) (RQ10)
               end else begin
                  take = 1'b1;
               end
            end
         end
         RRX_ST_FORCED: begin
            // Forced no-op: nothing executes, next word taken at its last phase
            if (q_r == Q_EXEC) begin
               rdy_nxt = 1'b1;
            end
            if (q_r == Q_LAST) begin
               state_nxt = RRX_ST_FIRST;
               take = 1'b1;
            end
         end
         default: state_nxt = RRX_ST_FIRST;
      endcase
      if (take) begin
         // A missing word runs as a no-op; status is re-mirrored per word
         if (i_instr_valid) begin
            op_nxt = dec_if.op;
            dest_nxt = dec_if.dest_file;
            field_nxt = dec_if.field;
            iaddr_nxt = i_instr_addr;
            sta_nxt = i_status_in;
         end else begin
            op_nxt = RRX_OP_NOP;
         end
      end
      busy_nxt = (state_nxt == RRX_ST_FORCED);
   end

   // Registers only; every next value comes from the block above
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_r <= RRX_ST_FIRST;
         q_r <= 2'h0;
         op_r <= RRX_OP_NOP;
         dest_r <= 1'b0;
         field_r <= 8'h00;
         iaddr_r <= 16'h0000;
         pc_r <= 16'h0000;
         pc_load_r <= 1'b0;
         pop_r <= 1'b0;
         pc_high_latch_r <= 8'h00;
         working_register_r <= 8'h00;
         sta_r <= 8'h00;
         fwd_r <= 8'h00;
         fwe_r <= 1'b0;
         unk_r <= 1'b0;
         rdy_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         q_r <= q_nxt;
         op_r <= op_nxt;
         dest_r <= dest_nxt;
         field_r <= field_nxt;
         iaddr_r <= iaddr_nxt;
         pc_r <= pc_nxt;
         pc_load_r <= pc_load_nxt;
         pop_r <= pop_nxt;
         pc_high_latch_r <= pc_high_latch_nxt;
         working_register_r <= working_register_nxt;
         sta_r <= sta_nxt;
         fwd_r <= fwd_nxt;
         fwe_r <= fwe_nxt;
         unk_r <= unk_nxt;
         rdy_r <= rdy_nxt;
         busy_r <= busy_nxt;
      end
   end

   // Outputs are plain copies of flops
   always_comb begin
      o_instr_ready = rdy_r;
      o_busy = busy_r;
      o_q_phase = q_r;
      o_pc = pc_r;
      o_pc_load = pc_load_r;
      o_stack_pop = pop_r;
      o_pc_high_latch = pc_high_latch_r;
      o_working_register = working_register_r;
      o_cpu_status_register = sta_r;
      o_file_addr = field_r;
      o_file_we = fwe_r;
      o_file_wdata = fwd_r;
      o_unknown = unk_r;
   end
endmodule // rrx_core

// ---- rrx_checker.sv ----
// Assertion checker for the return and rotate instruction executor
`timescale 1ns/10ps
module rrx_checker
   import rrx_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [rrx_pkg::PC_W-1:0] i_instr_addr,
   input wire logic [rrx_pkg::DATA_W-1:0] i_file_rdata,
   input wire logic [rrx_pkg::DATA_W-1:0] i_status_in,
   input wire logic o_instr_ready,
   input wire logic o_pc_load,
   input wire logic o_stack_pop,
   input wire logic o_file_we,
   input wire logic [rrx_pkg::DATA_W-1:0] o_pc_high_latch,
   input wire logic [rrx_pkg::DATA_W-1:0] o_working_register,
   input wire logic [rrx_pkg::DATA_W-1:0] o_cpu_status_register
);
   logic take;
   logic idle;
   assign take = o_instr_ready && i_instr_valid;
   // A missing word is taken as a no-op
   assign idle = o_instr_ready && (!i_instr_valid || i_instr == OP_NOP);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   ret_gap_a: assert property (
      take && (i_instr == OP_RET_INT || i_instr == OP_RET_SUB || i_instr[15:8] == OP_RET_LIT_HI)
      |=> !o_instr_ready [*7] ##1 o_instr_ready) else $error("return not two cycles");
   nop_gap_a: assert property (idle |=> !o_instr_ready [*3] ##1 o_instr_ready)
      else $error("no-op not one cycle");
   nop_quiet_a: assert property (idle |=> ##3 !o_pc_load && !o_stack_pop && !o_file_we)
      else $error("no-op had an effect");
   ret_int_a: assert property (
      take && i_instr == OP_RET_INT |=> ##3 o_pc_load && o_stack_pop
      && !o_cpu_status_register[GIE_DIS_BIT] && o_pc_high_latch == $past(o_pc_high_latch, 4))
      else $error("bad interrupt return");
   ret_lit_a: assert property (
      take && i_instr[15:8] == OP_RET_LIT_HI |=> ##3 o_pc_load && o_stack_pop
      && o_working_register == $past(i_instr[7:0], 4) && o_pc_high_latch == $past(o_pc_high_latch, 4))
      else $error("bad literal return");
   ret_flags_a: assert property (
      take && (i_instr == OP_RET_SUB || i_instr[15:8] == OP_RET_LIT_HI)
      |=> ##3 o_cpu_status_register == $past(i_status_in, 4)) else $error("return changed flags");
   ret_sub_a: assert property (
      take && i_instr == OP_RET_SUB |=> ##3 o_pc_load && o_stack_pop
      && o_pc_high_latch == $past(i_instr_addr[15:8], 4)) else $error("bad subroutine return");
   rot_carry_a: assert property (
      take && i_instr[15:9] == OP_ROT_LC_HI |=> ##3 o_cpu_status_register[CARRY_BIT] == $past(i_file_rdata[7], 1)
      && o_file_we == $past(i_instr[8], 4)) else $error("bad rotate carry");
   rot_working_register_a: assert property (
      take && i_instr[15:8] == {OP_ROT_LC_HI, 1'b0} |=> ##3
      o_working_register == {$past(i_file_rdata[6:0], 1), $past(i_status_in[CARRY_BIT], 1)}) else $error("bad rotate result");
   cover property (take && i_instr == OP_RET_INT);
   cover property (take && i_instr[15:8] == OP_RET_LIT_HI);
   cover property (take && i_instr[15:9] == OP_ROT_LC_HI && i_instr[8]);
endmodule // rrx_checker

bind rrx_core rrx_checker chk_u (.*);

// ---- tb_return_and_rotate_instr_exec.sv ----
// Self-checking bench for the return and rotate instruction executor
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: got %h, expected %h", $time, a, b); end end
module tb_return_and_rotate_instr_exec;
   import rrx_pkg::*;
   typedef struct {logic [15:0] ins, adr, stk, ep; logic [7:0] fil, sti, ew, es, el;} rrx_row_t;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0;
   logic [15:0] i_instr = '0, i_instr_addr = '0, i_stack_top = '0;
   logic [7:0] i_file_rdata = '0, i_status_in = '0;
   logic o_instr_ready, o_busy, o_pc_load, o_stack_pop, o_file_we, o_unknown;
   logic [1:0] o_q_phase;
   logic [15:0] o_pc;
   logic [7:0] o_pc_high_latch, o_working_register, o_cpu_status_register, o_file_addr, o_file_wdata;
   int num_errors = 0, total_checks = 0;
   rrx_row_t rows [7];
   rrx_core dut_u (.*);
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Called at a falling edge; returns at the falling edge after the effects land, or one falling edge later for a return
   task automatic run(input rrx_row_t r);
      int k;
      logic fw;
      logic unk;
      fw = (r.ins[15:9] == OP_ROT_LC_HI) && r.ins[8];
      unk = (r.ins != OP_NOP) && (r.ins != OP_RET_INT) && (r.ins != OP_RET_SUB)
         && (r.ins[15:8] != OP_RET_LIT_HI) && (r.ins[15:9] != OP_ROT_LC_HI);
      {i_instr, i_instr_addr, i_stack_top, i_file_rdata, i_status_in} = {r.ins, r.adr, r.stk, r.fil, r.sti};
      i_instr_valid = 1'b1;
      k = 0;
      while (o_instr_ready !== 1'b1 && k < 12) begin
         @(negedge i_clk_sys);
         k++;
      end
      if (k == 12) num_errors++;
      repeat (4) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      `CHK(fw ? o_file_wdata : o_working_register, r.ew)
      `CHK(o_file_we, fw)
      `CHK(o_cpu_status_register, r.es)
      `CHK(o_pc_high_latch, r.el)
      `CHK(o_stack_pop, |r.ep)
      if (|r.ep) `CHK(o_pc, r.ep)
      `CHK(o_pc_load, |r.ep)
      `CHK(o_unknown, unk)
      `CHK(o_q_phase, Q_LAST)
      `CHK(o_busy, 1'b0)
      if (r.ins[15:9] == OP_ROT_LC_HI) `CHK(o_file_addr, r.ins[7:0])
      // A return spends the next instruction cycle as a forced no-op
      if (|r.ep) begin
         @(negedge i_clk_sys);
         `CHK(o_busy, 1'b1)
      end
   endtask
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   // Whole run is near 0.56 us; about nine times that means a hang
   initial begin
      #5000;
      num_errors++;
      wrap_up();
   end
   initial begin
      rows = '{'{16'hb6a5, 16'h0100, 16'h1234, 16'h1234, 8'h00, 8'h10, 8'ha5, 8'h10, 8'h00},
               '{16'h0002, 16'h3c40, 16'h0456, 16'h0456, 8'h00, 8'h13, 8'ha5, 8'h13, 8'h3c},
               '{16'h0005, 16'h0200, 16'h0789, 16'h0789, 8'h00, 8'hff, 8'ha5, 8'hef, 8'h3c},
               '{16'h1a07, 16'h0300, 16'h0000, 16'h0000, 8'he6, 8'h00, 8'hcc, 8'h01, 8'h3c},
               '{16'h1b07, 16'h0300, 16'h0000, 16'h0000, 8'h4d, 8'h01, 8'h9b, 8'h00, 8'h3c},
               '{16'h0000, 16'h0300, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'hcc, 8'h00, 8'h3c},
               '{16'h3400, 16'h0300, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'hcc, 8'h00, 8'h3c}};
      repeat (4) @(negedge i_clk_sys);
      `CHK(o_instr_ready, 1'b0)
      `CHK(o_cpu_status_register, 8'h00)
      i_rst = 1'b0;
      foreach (rows[i]) run(rows[i]);
      // Reset in mid-run, then the largest literal
      i_instr_valid = 1'b0;
      i_rst = 1'b1;
      @(negedge i_clk_sys);
      `CHK(o_working_register, 8'h00)
      i_rst = 1'b0;
      run('{16'hb6ff, 16'h0400, 16'h0abc, 16'h0abc, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00});
      wrap_up();
   end
endmodule // tb_return_and_rotate_instr_exec
